// file: rtl/pad_input_sync.sv
// Two flip-flop synchroniser for the sixteen pad inputs
`timescale 1ns/10ps
module pad_input_sync
  import port3_mux_pkg::*;
(
  input  wire logic                mclk_i,
  input  wire logic                reset_i,
  input  wire logic [NUM_PINS-1:0] pad_in_i,
  output logic      [NUM_PINS-1:0] pad_sync_o
);

  sync_state_t state;
  sync_state_t next_state;

  // First stage feeds only the second stage
  always_comb begin
    next_state        = state;
    next_state.meta   = pad_in_i;
    next_state.stable = state.meta;
  end

  // State register
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign pad_sync_o = state.stable;

endmodule

// file: rtl/pin_route_cell.sv
// Combinational routing of one pad to one of its functions
`timescale 1ns/10ps
module pin_route_cell
  import port3_mux_pkg::*;
(
  input  wire logic [SEL_W-1:0]    code_i,
  input  wire logic                legal_i,
  input  wire logic [NUM_FUNC-1:0] func_out_i,
  input  wire logic [NUM_FUNC-1:0] func_oe_i,
  input  wire logic                pad_in_i,
  output logic                     pad_out_o,
  output logic                     pad_oe_n_o,
  output logic [NUM_FUNC-1:0]      func_in_o
);

  logic [2:0] idx;

  // Reserved codes release the pad and feed no function
  always_comb begin
    idx        = code_i[2:0];
    pad_out_o  = 1'b0;
    pad_oe_n_o = 1'b1;
    func_in_o  = '0;
    if (legal_i && (code_i < SEL_W'(NUM_FUNC))) begin
      pad_out_o      = func_out_i[idx];
      pad_oe_n_o     = ~func_oe_i[idx];
      func_in_o[idx] = pad_in_i;
    end
  end

endmodule

// file: rtl/port3_cd_pin_mux.sv
// Pin-function selector registers and pad routing, port 3 groups C and D
`timescale 1ns/10ps
module port3_cd_pin_mux
  import port3_mux_pkg::*;
(
  input  wire logic                mclk_i,
  input  wire logic                reset_i,
  input  wire logic [ADDR_W-1:0]   addr_i,
  input  wire logic [DATA_W-1:0]   wdata_i,
  input  wire logic                wr_i,
  input  wire logic                rd_i,
  output logic      [DATA_W-1:0]   rdata_o,
  input  wire func_drive_t         func_drive_i,
  output func_vec_t                func_in_o,
  input  wire logic [NUM_PINS-1:0] pad_in_i,
  output logic      [NUM_PINS-1:0] pad_out_o,
  output logic      [NUM_PINS-1:0] pad_oe_n_o,
  output sel_bank_t                sel_o
);

  mux_state_t          state;
  mux_state_t          next_state;
  logic [NUM_PINS-1:0] pad_sync;
  logic [NUM_PINS-1:0] legal;
  logic [NUM_PINS-1:0] cell_out;
  logic [NUM_PINS-1:0] cell_oe_n;
  func_vec_t           cell_func_in;

  // Highest listed code per pin; pins 0..7 are group C, 8..15 group D
  function automatic logic code_listed(input int unsigned pin, input logic [3:0] code);
    logic ok;
    ok = 1'b0;
    case (pin)
      0:       ok = (code <= CODE_ALT2);
      1:       ok = (code <= CODE_ALT2);
      2:       ok = (code <= CODE_ALT3);
      3:       ok = (code <= CODE_ALT3);
      4:       ok = (code <= CODE_ALT3);
      5:       ok = (code <= CODE_ALT3);
      6:       ok = (code <= CODE_ALT3);
      7:       ok = (code <= CODE_ALT3);
      8:       ok = (code <= CODE_ALT3);
      9:       ok = (code <= CODE_ALT4);
      10:      ok = (code <= CODE_ALT4);
      11:      ok = (code <= CODE_ALT4);
      12:      ok = (code == CODE_GPIO);
      default: ok = (code == CODE_GPIO);
    endcase
    return ok;
  endfunction

  // Pad inputs come from outside the clock domain
  pad_input_sync u_sync (
    .mclk_i     (mclk_i),
    .reset_i    (reset_i),
    .pad_in_i   (pad_in_i),
    .pad_sync_o (pad_sync)
  );

  // One routing cell per pad
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    assign legal[p] = code_listed(p, state.sel[p]);
    pin_route_cell u_cell (
      .code_i     (state.sel[p]),
      .legal_i    (legal[p]),
      .func_out_i (func_drive_i.out[p]),
      .func_oe_i  (func_drive_i.oe[p]),
      .pad_in_i   (pad_sync[p]),
      .pad_out_o  (cell_out[p]),
      .pad_oe_n_o (cell_oe_n[p]),
      .func_in_o  (cell_func_in[p])
    );
  end

  // Register writes, read data and registered pad outputs
  always_comb begin
    next_state          = state;
    next_state.rdata    = RDATA_RESET;
    next_state.pad_out  = cell_out;
    next_state.pad_oe_n = cell_oe_n;
    next_state.func_in  = cell_func_in;
    if (wr_i) begin
      if (addr_i == OFF_C_LOW) begin
        next_state.sel[3:0]   = masked_update(state.sel[3:0], wdata_i);
      end else if (addr_i == OFF_C_HIGH) begin
        next_state.sel[7:4]   = masked_update(state.sel[7:4], wdata_i);
      end else if (addr_i == OFF_D_LOW) begin
        next_state.sel[11:8]  = masked_update(state.sel[11:8], wdata_i);
      end else if (addr_i == OFF_D_HIGH) begin
        next_state.sel[15:12] = masked_update(state.sel[15:12], wdata_i);
      end
    end
    if (rd_i) begin
      if (addr_i == OFF_C_LOW) begin
        next_state.rdata = {MASK_READ_VALUE, state.sel[3:0]};
      end else if (addr_i == OFF_C_HIGH) begin
        next_state.rdata = {MASK_READ_VALUE, state.sel[7:4]};
      end else if (addr_i == OFF_D_LOW) begin
        next_state.rdata = {MASK_READ_VALUE, state.sel[11:8]};
      end else if (addr_i == OFF_D_HIGH) begin
        next_state.rdata = {MASK_READ_VALUE, state.sel[15:12]};
      end
    end
  end

  // State register; all selectors start at GPIO
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state          <= '0;
      state.sel      <= {NUM_PINS{SEL_RESET}};
      state.pad_oe_n <= '1;
    end else begin
      state <= next_state;
    end
  end

  assign rdata_o    = state.rdata;
  assign pad_out_o  = state.pad_out;
  assign pad_oe_n_o = state.pad_oe_n;
  assign func_in_o  = state.func_in;
  assign sel_o      = state.sel;

  // Checks on register and routing behaviour
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  property p_mask_blocks;
    wr_i && (addr_i == OFF_C_LOW) && (wdata_i[31:16] == 16'h0000)
      |=> (state.sel[3:0] == $past(state.sel[3:0]));
  endproperty
  a_mask_blocks: assert property (p_mask_blocks)
    else $error("masked-off selector bits changed");

  property p_mask_writes;
    wr_i && (addr_i == OFF_D_LOW) && (wdata_i[31:16] == 16'hFFFF) && !rd_i
      ##1 rd_i && (addr_i == OFF_D_LOW) && !wr_i
      |=> (rdata_o == {16'h0000, $past(wdata_i[15:0], 2)});
  endproperty
  a_mask_writes: assert property (p_mask_writes)
    else $error("fully enabled write did not read back");

  property p_mask_reads_zero;
    rd_i |=> (rdata_o[31:16] == 16'h0000);
  endproperty
  a_mask_reads_zero: assert property (p_mask_reads_zero)
    else $error("mask half read as nonzero");

  property p_c3_pwm;
    (state.sel[3] == CODE_ALT3) |=> (pad_out_o[3] == $past(func_drive_i.out[3][3]));
  endproperty
  a_c3_pwm: assert property (p_c3_pwm)
    else $error("pin C3 code 3 not routed to its function");

  property p_c0_reserved;
    (state.sel[0] == CODE_ALT3) |=> pad_oe_n_o[0] && (func_in_o[0] == 5'h00);
  endproperty
  a_c0_reserved: assert property (p_c0_reserved)
    else $error("pin C0 reserved code drives the pad");

  property p_c6_mic_clock;
    (state.sel[6] == CODE_ALT2) |=> (pad_oe_n_o[6] == !$past(func_drive_i.oe[6][2]));
  endproperty
  a_c6_mic_clock: assert property (p_c6_mic_clock)
    else $error("pin C6 code 2 enable mismatch");

  property p_c5_audio_in;
    (state.sel[5] == CODE_ALT2) |=> (func_in_o[5][2] == $past(pad_sync[5]));
  endproperty
  a_c5_audio_in: assert property (p_c5_audio_in)
    else $error("pin C5 input not delivered to audio receiver");

  property p_c4_gpio;
    (state.sel[4] == CODE_GPIO) |=> (pad_out_o[4] == $past(func_drive_i.out[4][0]));
  endproperty
  a_c4_gpio: assert property (p_c4_gpio)
    else $error("pin C4 gpio path broken");

  property p_d3_flash;
    (state.sel[11] == CODE_ALT4) |=> (pad_out_o[11] == $past(func_drive_i.out[11][4]));
  endproperty
  a_d3_flash: assert property (p_d3_flash)
    else $error("pin D3 flash trigger not routed");

  property p_d0_reserved;
    (state.sel[8] == CODE_ALT4) |=> pad_oe_n_o[8];
  endproperty
  a_d0_reserved: assert property (p_d0_reserved)
    else $error("pin D0 code 4 drives the pad");

  property p_d_high_reset;
    $past(reset_i) |-> (state.sel[15:12] == 16'h0000);
  endproperty
  a_d_high_reset: assert property (p_d_high_reset)
    else $error("group D high selectors not zero after reset");

  property p_d4_gpio_only;
    (state.sel[12] != CODE_GPIO) |=> pad_oe_n_o[12];
  endproperty
  a_d4_gpio_only: assert property (p_d4_gpio_only)
    else $error("pin D4 nonzero code drives the pad");

  // Further routing checks on eleven of the pins, then a read-data window check
  property p_c3_display;
    (state.sel[3] == CODE_DISPLAY) |=> (pad_out_o[3] == $past(func_drive_i.out[3][1]));
  endproperty
  a_c3_display: assert property (p_c3_display)
    else $error("pin C3 display code not routed");

  property p_c2_frame;
    (state.sel[2] == CODE_ALT2) |=> (pad_out_o[2] == $past(func_drive_i.out[2][2]));
  endproperty
  a_c2_frame: assert property (p_c2_frame)
    else $error("pin C2 frame clock not routed");

  property p_c1_mclk;
    (state.sel[1] == CODE_ALT2) |=> (pad_oe_n_o[1] == !$past(func_drive_i.oe[1][2]));
  endproperty
  a_c1_mclk: assert property (p_c1_mclk)
    else $error("pin C1 master clock enable mismatch");

  property p_c1_reserved;
    (state.sel[1] == CODE_ALT3) |=> pad_oe_n_o[1] && !pad_out_o[1];
  endproperty
  a_c1_reserved: assert property (p_c1_reserved)
    else $error("pin C1 reserved code drives the pad");

  property p_c7_camera;
    (state.sel[7] == CODE_ALT3) |=> (func_in_o[7][3] == $past(pad_sync[7]));
  endproperty
  a_c7_camera: assert property (p_c7_camera)
    else $error("pin C7 input not delivered to camera");

  property p_c4_audio_out;
    (state.sel[4] == CODE_ALT2) |=> (pad_out_o[4] == $past(func_drive_i.out[4][2]));
  endproperty
  a_c4_audio_out: assert property (p_c4_audio_out)
    else $error("pin C4 audio out not routed");

  property p_d3_camera_clk;
    (state.sel[11] == CODE_ALT3) |=> (func_in_o[11][3] == $past(pad_sync[11]));
  endproperty
  a_d3_camera_clk: assert property (p_d3_camera_clk)
    else $error("pin D3 camera clock input not delivered");

  property p_d2_strobe;
    (state.sel[10] == CODE_ALT4) |=> (pad_out_o[10] == $past(func_drive_i.out[10][4]));
  endproperty
  a_d2_strobe: assert property (p_d2_strobe)
    else $error("pin D2 strobe trigger not routed");

  property p_d1_prelight;
    (state.sel[9] == CODE_ALT4) |=> (pad_oe_n_o[9] == !$past(func_drive_i.oe[9][4]));
  endproperty
  a_d1_prelight: assert property (p_d1_prelight)
    else $error("pin D1 prelight enable mismatch");

  property p_d0_clock_out;
    (state.sel[8] == CODE_ALT3) |=> (pad_oe_n_o[8] == !$past(func_drive_i.oe[8][3]));
  endproperty
  a_d0_clock_out: assert property (p_d0_clock_out)
    else $error("pin D0 camera clock out enable mismatch");

  property p_d_high_gpio;
    (state.sel[13] != CODE_GPIO) |=> pad_oe_n_o[13] && (func_in_o[13] == 5'h00);
  endproperty
  a_d_high_gpio: assert property (p_d_high_gpio)
    else $error("pin D5 nonzero code is routed");

  property p_d4_osc_in;
    (state.sel[12] == CODE_GPIO) |=> (func_in_o[12][0] == $past(pad_sync[12]));
  endproperty
  a_d4_osc_in: assert property (p_d4_osc_in)
    else $error("pin D4 input not delivered on code zero");

  property p_read_window;
    !rd_i |=> (rdata_o == 32'h0000_0000);
  endproperty
  a_read_window: assert property (p_read_window)
    else $error("read data outside its one cycle window");

  // Main scenarios
  c_d2_strobe:      cover property (state.sel[10] == CODE_ALT4);
  c_c1_mclk:        cover property (state.sel[1] == CODE_ALT2);
  c_partial_mask:   cover property (wr_i && (wdata_i[31:16] == 16'h00F0));
  c_write_then_read: cover property (wr_i ##1 rd_i);
  c_c0_reserved:    cover property (state.sel[0] == CODE_ALT3);

endmodule

// file: rtl/port3_mux_pkg.sv
// Shared constants and types for the port 3 C/D pin-function selectors
package port3_mux_pkg;

  // Register map, byte addresses
  localparam int          ADDR_W           = 8;
  localparam int          DATA_W           = 32;
  localparam logic [7:0]  OFF_C_LOW        = 8'h50;
  localparam logic [7:0]  OFF_C_HIGH       = 8'h54;
  localparam logic [7:0]  OFF_D_LOW        = 8'h58;
  localparam logic [7:0]  OFF_D_HIGH       = 8'h5C;

  // Field layout
  localparam int          NUM_PINS         = 16;
  localparam int          SEL_W            = 4;
  localparam int          PINS_PER_REG     = 4;
  localparam int          NUM_REGS         = 4;
  localparam int          NUM_FUNC         = 5;
  localparam int          MASK_LSB         = 16;
  localparam int          HALF_W           = 16;

  // Reset values
  localparam logic [3:0]  SEL_RESET        = 4'h0;
  localparam logic [31:0] RDATA_RESET      = 32'h0000_0000;
  localparam logic [15:0] MASK_READ_VALUE  = 16'h0000;

  // Selector codes
  localparam logic [3:0]  CODE_GPIO        = 4'h0;
  localparam logic [3:0]  CODE_DISPLAY     = 4'h1;
  localparam logic [3:0]  CODE_ALT2        = 4'h2;
  localparam logic [3:0]  CODE_ALT3        = 4'h3;
  localparam logic [3:0]  CODE_ALT4        = 4'h4;

  typedef logic [NUM_PINS-1:0][SEL_W-1:0]    sel_bank_t;
  typedef logic [NUM_PINS-1:0][NUM_FUNC-1:0] func_vec_t;

  // Drive request from the function side toward the pads
  typedef struct packed {
    func_vec_t out;
    func_vec_t oe;
  } func_drive_t;

  // Whole state of the selector block
  typedef struct packed {
    sel_bank_t             sel;
    logic [DATA_W-1:0]     rdata;
    logic [NUM_PINS-1:0]   pad_out;
    logic [NUM_PINS-1:0]   pad_oe_n;
    func_vec_t             func_in;
  } mux_state_t;

  // Two-stage pad input synchroniser state
  typedef struct packed {
    logic [NUM_PINS-1:0] meta;
    logic [NUM_PINS-1:0] stable;
  } sync_state_t;

  // Masked write: upper half enables each lower bit
  function automatic logic [15:0] masked_update(input logic [15:0] old_val,
                                                input logic [31:0] wdata);
    logic [15:0] mask;
    mask = wdata[31:16];
    return (old_val & ~mask) | (wdata[15:0] & mask);
  endfunction

endpackage

// file: testbench/tb_gpio_port3_cd_pin_function_select.sv
// Self-checking bench for the port 3 group C/D pin-function selectors
`timescale 1ns/10ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; $display("unexpected %s exp=%0h got=%0h", nm, e, g); end end
module tb_gpio_port3_cd_pin_function_select import port3_mux_pkg::*; ;
  logic                mclk_i = 1'b0;
  logic                reset_i;
  logic [ADDR_W-1:0]   addr_i;
  logic [DATA_W-1:0]   wdata_i;
  logic                wr_i;
  logic                rd_i;
  logic [DATA_W-1:0]   rdata_o;
  func_drive_t         func_drive_i;
  func_vec_t           func_in_o;
  logic [NUM_PINS-1:0] pad_in_i;
  logic [NUM_PINS-1:0] pad_out_o;
  logic [NUM_PINS-1:0] pad_oe_n_o;
  sel_bank_t           sel_o;
  sel_bank_t           model;
  logic [7:0]          reg_off [4] = '{OFF_C_LOW, OFF_C_HIGH, OFF_D_LOW, OFF_D_HIGH};
  int                  n_fail = 0;
  int                  compares = 0;
  int                  cycles = 0;

  port3_cd_pin_mux dut_u (
    .mclk_i(mclk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .func_drive_i(func_drive_i),
    .func_in_o(func_in_o), .pad_in_i(pad_in_i), .pad_out_o(pad_out_o),
    .pad_oe_n_o(pad_oe_n_o), .sel_o(sel_o)
  );

  // Clock and hang guard
  always #10 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      wrap_up();
    end
  end

  // Codes listed for each pin; everything else is reserved
  function automatic logic legal(int p, int c);
    if (c == 0) return 1'b1;
    if (p >= 12) return 1'b0;
    if (c <= 2) return 1'b1;
    if (c == 3) return p >= 2;
    return (c == 4) && (p >= 9);
  endfunction

  // Expected read data: selector half from model, mask half zero
  function automatic logic [31:0] exp_rd(logic [7:0] a);
    for (int r = 0; r < 4; r++) begin
      if (a == reg_off[r]) return {16'h0000, model[4*r+3 -: 4]};
    end
    return 32'h0000_0000;
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    for (int r = 0; r < 4; r++) begin
      if (a == reg_off[r]) model[4*r+3 -: 4] = (model[4*r+3 -: 4] & ~d[31:16]) | (d[15:0] & d[31:16]);
    end
    #1;
    `CHK("sel_o", model, sel_o)
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge mclk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    `CHK("rdata_o", exp_rd(a), rdata_o)
  endtask

  // Select code c on pin p with fresh random function and pad values
  task automatic route(input int p, input int c);
    logic       e_out;
    logic       e_oen;
    logic [4:0] e_fin;
    @(posedge mclk_i);
    func_drive_i <= {$urandom, $urandom, $urandom, $urandom, $urandom};
    pad_in_i     <= 16'($urandom);
    wr(reg_off[p/4], (32'hF << (16 + 4 * (p % 4))) | (32'(c) << (4 * (p % 4))));
    repeat (4) @(posedge mclk_i);
    #1;
    e_out = 1'b0;
    e_oen = 1'b1;
    e_fin = 5'h00;
    if (legal(p, c)) begin
      e_out = func_drive_i.out[p][c];
      e_oen = ~func_drive_i.oe[p][c];
      e_fin = 5'(pad_in_i[p]) << c;
    end
    `CHK("pad_out_o", e_out, pad_out_o[p])
    `CHK("pad_oe_n_o", e_oen, pad_oe_n_o[p])
    `CHK("func_in_o", e_fin, func_in_o[p])
  endtask

  task automatic wrap_up();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    logic [7:0]  a;
    logic [31:0] d;
    reset_i      = 1'b1;
    wr_i         = 1'b0;
    rd_i         = 1'b0;
    addr_i       = 8'h00;
    wdata_i      = 32'h0000_0000;
    func_drive_i = '0;
    pad_in_i     = 16'h0000;
    model        = '0;
    void'($urandom(37696));
    repeat (2) @(posedge mclk_i);
    reset_i <= 1'b0;
    #1;
    `CHK("sel_o", model, sel_o)
    `CHK("pad_oe_n_o", 16'hFFFF, pad_oe_n_o)
    for (int r = 0; r < 4; r++) begin
      rd(reg_off[r]);
    end
    rd(8'h60);
    @(posedge mclk_i);
    #1;
    `CHK("rdata_o", 32'h0000_0000, rdata_o)
    wr(8'h60, 32'hFFFF_FFFF);
    // Masked writes: none, all, then random, unmapped now and then
    for (int i = 0; i < 60; i++) begin
      a = (i % 7 == 6) ? 8'h44 : reg_off[$urandom % 4];
      d = (i == 0) ? 32'h0000_FFFF : (i == 1) ? 32'hFFFF_4321 : $urandom;
      wr(a, d);
      rd(a);
    end
    // Write then read with no idle cycle; the read sees the new value
    for (int i = 0; i < 4; i++) begin
      d = $urandom | 32'hFFFF_0000;
      @(posedge mclk_i);
      wr_i    <= 1'b1;
      addr_i  <= OFF_D_LOW;
      wdata_i <= d;
      @(posedge mclk_i);
      wr_i <= 1'b0;
      rd_i <= 1'b1;
      model[11:8] = d[15:0];
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1;
      `CHK("rdata_o", exp_rd(OFF_D_LOW), rdata_o)
    end
    // Codes 0 to 5 on every pin: every listed code plus one or more reserved ones
    for (int p = 0; p < NUM_PINS; p++) begin
      for (int c = 0; c <= 5; c++) begin
        route(p, c);
      end
    end
    wrap_up();
  end
endmodule
